// file: rtl/wake_csum_pkg.sv
// Package of offsets, field positions, reset values and states for the wake and checksum bank.
//
// Notes on behaviour
// - After the eighth filter write the write pointer wraps to entry zero.
// - Filter reads return stored entries in order, read pointer advancing per read.
// - With unicast wake enabled, a frame with group bit zero ends power saving.
// - Wake frame seen flag sets on a valid wake frame; software clears it.
// - Magic frame seen flag sets on a valid magic frame; software clears it.
// - Wake frame enable turns on wake frame detection using the filter contents.
// - Magic wake enable turns magic frame wakeup on; clear means it is off.
// - Transmit checksum enable bypasses the engine at 0, engages at 1; resets 0.
// - Start select 0 starts after 14 bytes; 1 starts at the layer-3 header.
// - Receive checksum enable bypasses the engine at 0, engages at 1; resets 0.
// - The VLAN tag identifier marks VLAN tags for the engine; resets to all ones.
`default_nettype none
package wake_csum_pkg;
  localparam int unsigned ADDR_W         = 8;
  localparam int unsigned DATA_W         = 32;
  localparam logic [7:0]  OFS_FILTER     = 8'hA8;
  localparam logic [7:0]  OFS_WAKE       = 8'hAC;
  localparam logic [7:0]  OFS_CSUM       = 8'hB0;
  localparam logic [7:0]  OFS_VLAN       = 8'hB4;
  localparam int unsigned FILTER_WORDS   = 8;
  localparam int unsigned PTR_W          = 3;
  localparam int unsigned BIT_UNICAST_EN = 9;
  localparam int unsigned BIT_FRAME_SEEN = 6;
  localparam int unsigned BIT_MAGIC_SEEN = 5;
  localparam int unsigned BIT_FRAME_EN   = 2;
  localparam int unsigned BIT_MAGIC_EN   = 1;
  localparam int unsigned BIT_TX_CSUM_EN = 16;
  localparam int unsigned BIT_RX_START   = 1;
  localparam int unsigned BIT_RX_CSUM_EN = 0;
  localparam logic [31:0] FILTER_RESET   = 32'h0000_0000;
  localparam logic [15:0] VLAN_ID_RESET  = 16'hFFFF;
  localparam logic [7:0]  ETH_HDR_BYTES  = 8'h0E;
  localparam logic [7:0]  L3_START_BYTES = 8'h00;

  typedef enum logic [2:0] {
    PS_AWAKE  = 3'b001,
    PS_SLEEP  = 3'b010,
    PS_WAKING = 3'b100
  } power_state_t;
endpackage : wake_csum_pkg
`default_nettype wire

// file: rtl/wake_filter_store.sv
// Indexed store of the wake frame filter words with separate read and write pointers.
`timescale 1ns/10ps
`default_nettype none
module wake_filter_store
  import wake_csum_pkg::*;
#(
  parameter int unsigned WORDS = FILTER_WORDS,
  parameter int unsigned WIDTH = DATA_W,
  parameter int unsigned PW    = PTR_W
) (
  input  wire logic               clock,
  input  wire logic               rstn,
  input  wire logic               wr_en,
  input  wire logic               rd_en,
  input  wire logic [WIDTH-1:0]   wdata,
  output logic      [WIDTH-1:0]   rd_word,
  output logic      [WORDS*WIDTH-1:0] contents,
  output logic      [PW-1:0]      wr_ptr_q,
  output logic      [PW-1:0]      rd_ptr_q
);
  logic [WIDTH-1:0] mem_q [WORDS];
  localparam logic [PW-1:0] LAST = PW'(WORDS - 1);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_q[i] <= FILTER_RESET[WIDTH-1:0];
      end
    end else if (wr_en) begin
      mem_q[wr_ptr_q] <= wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      wr_ptr_q <= '0;
    end else if (wr_en) begin
      wr_ptr_q <= (wr_ptr_q == LAST) ? '0 : wr_ptr_q + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rd_ptr_q <= '0;
    end else if (rd_en) begin
      rd_ptr_q <= (rd_ptr_q == LAST) ? '0 : rd_ptr_q + 1'b1;
    end
  end

  assign rd_word = mem_q[rd_ptr_q];

  for (genvar g = 0; g < WORDS; g++) begin : g_flat
    assign contents[g*WIDTH +: WIDTH] = mem_q[g];
  end
endmodule : wake_filter_store
`default_nettype wire

// file: rtl/wake_csum_regs.sv
// Wake filter, wake control and status, and checksum offload control registers.
`timescale 1ns/10ps
`default_nettype none
module wake_csum_regs
  import wake_csum_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    rstn,
  input  wire logic [ADDR_W-1:0]       reg_addr,
  input  wire logic [DATA_W-1:0]       reg_wdata,
  input  wire logic                    reg_write,
  input  wire logic                    reg_read,
  output logic      [DATA_W-1:0]       reg_rdata,
  input  wire logic                    wake_frame_match,
  input  wire logic                    magic_frame_match,
  input  wire logic                    rx_frame_done,
  input  wire logic                    rx_dest_group,
  input  wire logic                    sleep_request,
  output logic [FILTER_WORDS*DATA_W-1:0] wake_filter_contents,
  output logic                         wake_frame_enable,
  output logic                         magic_wake_enable,
  output logic                         unicast_wake_enable,
  output logic                         wake_frame_seen,
  output logic                         magic_frame_seen,
  output logic                         power_save,
  output logic                         wake_up,
  output logic                         tx_checksum_enable,
  output logic                         rx_checksum_enable,
  output logic                         rx_checksum_start_select,
  output logic [7:0]                   rx_checksum_start_bytes,
  output logic [15:0]                  vlan_tag_ident_one
);

  // ****************************************
  // Address decode
  // ****************************************

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic wr_filter;
  logic rd_filter;
  logic wr_wake;
  logic wr_csum;
  logic wr_vlan;

  assign wr_filter = reg_write && hit(reg_addr, OFS_FILTER);
  assign rd_filter = reg_read && hit(reg_addr, OFS_FILTER);
  assign wr_wake   = reg_write && hit(reg_addr, OFS_WAKE);
  assign wr_csum   = reg_write && hit(reg_addr, OFS_CSUM);
  assign wr_vlan   = reg_write && hit(reg_addr, OFS_VLAN);

  // ****************************************
  // Wake filter store
  // ****************************************

  logic [DATA_W-1:0] filter_word;
  logic [PTR_W-1:0]  filter_wr_ptr;
  logic [PTR_W-1:0]  filter_rd_ptr;

  wake_filter_store #(
    .WORDS (FILTER_WORDS),
    .WIDTH (DATA_W),
    .PW    (PTR_W)
  ) u_filter (
    .clock    (clock),
    .rstn     (rstn),
    .wr_en    (wr_filter),
    .rd_en    (rd_filter),
    .wdata    (reg_wdata),
    .rd_word  (filter_word),
    .contents (wake_filter_contents),
    .wr_ptr_q (filter_wr_ptr),
    .rd_ptr_q (filter_rd_ptr)
  );

  // ****************************************
  // Wake control bits
  // ****************************************

  always_ff @(posedge clock) begin
    if (!rstn) begin
      wake_frame_enable <= 1'b0;
    end else if (wr_wake) begin
      wake_frame_enable <= reg_wdata[BIT_FRAME_EN];
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      magic_wake_enable <= 1'b0;
    end else if (wr_wake) begin
      magic_wake_enable <= reg_wdata[BIT_MAGIC_EN];
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      unicast_wake_enable <= 1'b0;
    end else if (wr_wake) begin
      unicast_wake_enable <= reg_wdata[BIT_UNICAST_EN];
    end
  end

  // ****************************************
  // Wake event flags
  // ****************************************

  logic frame_event;
  logic magic_event;
  logic unicast_event;

  assign frame_event   = wake_frame_match && wake_frame_enable;
  assign magic_event   = magic_frame_match && magic_wake_enable;
  assign unicast_event = rx_frame_done && !rx_dest_group && unicast_wake_enable;

  // A new event in the clearing cycle keeps the flag set.
  // wake frame flag
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wake_frame_seen <= 1'b0;
    end else if (frame_event) begin
      wake_frame_seen <= 1'b1;
    end else if (wr_wake && reg_wdata[BIT_FRAME_SEEN]) begin
      wake_frame_seen <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      magic_frame_seen <= 1'b0;
    end else if (magic_event) begin
      magic_frame_seen <= 1'b1;
    end else if (wr_wake && reg_wdata[BIT_MAGIC_SEEN]) begin
      magic_frame_seen <= 1'b0;
    end
  end

  // ****************************************
  // Power saving state
  // ****************************************

  power_state_t ps_q;
  power_state_t ps_d;
  logic         wake_hit;

  assign wake_hit = frame_event || magic_event || unicast_event;

  always_comb begin
    ps_d = ps_q;
    case (ps_q)
      PS_AWAKE: begin
        if (sleep_request) begin
          ps_d = PS_SLEEP;
        end
      end
      PS_SLEEP: begin
        if (wake_hit) begin
          ps_d = PS_WAKING;
        end
      end
      PS_WAKING: begin
        ps_d = PS_AWAKE;
      end
      default: begin
        ps_d = PS_AWAKE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      ps_q <= PS_AWAKE;
    end else begin
      ps_q <= ps_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      power_save <= 1'b0;
      wake_up    <= 1'b0;
    end else begin
      power_save <= (ps_d == PS_SLEEP);
      wake_up    <= (ps_d == PS_WAKING);
    end
  end

  // ****************************************
  // Checksum offload control
  // ****************************************

  always_ff @(posedge clock) begin
    if (!rstn) begin
      tx_checksum_enable <= 1'b0;
    end else if (wr_csum) begin
      tx_checksum_enable <= reg_wdata[BIT_TX_CSUM_EN];
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rx_checksum_enable <= 1'b0;
    end else if (wr_csum) begin
      rx_checksum_enable <= reg_wdata[BIT_RX_CSUM_EN];
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rx_checksum_start_select <= 1'b0;
      rx_checksum_start_bytes  <= ETH_HDR_BYTES;
    end else if (wr_csum) begin
      rx_checksum_start_select <= reg_wdata[BIT_RX_START];
      rx_checksum_start_bytes  <= reg_wdata[BIT_RX_START] ? L3_START_BYTES : ETH_HDR_BYTES;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      vlan_tag_ident_one <= VLAN_ID_RESET;
    end else if (wr_vlan) begin
      vlan_tag_ident_one <= reg_wdata[15:0];
    end
  end

  // ****************************************
  // Read data
  // ****************************************

  logic [DATA_W-1:0] wake_view;
  logic [DATA_W-1:0] csum_view;
  logic [DATA_W-1:0] rdata_d;

  always_comb begin
    wake_view                 = '0;
    wake_view[BIT_UNICAST_EN] = unicast_wake_enable;
    wake_view[BIT_FRAME_SEEN] = wake_frame_seen;
    wake_view[BIT_MAGIC_SEEN] = magic_frame_seen;
    wake_view[BIT_FRAME_EN]   = wake_frame_enable;
    wake_view[BIT_MAGIC_EN]   = magic_wake_enable;
    csum_view                 = '0;
    csum_view[BIT_TX_CSUM_EN] = tx_checksum_enable;
    csum_view[BIT_RX_START]   = rx_checksum_start_select;
    csum_view[BIT_RX_CSUM_EN] = rx_checksum_enable;
  end

  always_comb begin
    rdata_d = '0;
    if (reg_read) begin
      case (reg_addr)
        OFS_FILTER: begin
          rdata_d = filter_word;
        end
        OFS_WAKE: begin
          rdata_d = wake_view;
        end
        OFS_CSUM: begin
          rdata_d = csum_view;
        end
        OFS_VLAN: begin
          rdata_d = {16'h0000, vlan_tag_ident_one};
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  sequence s_sleeping_hit;
    (ps_q == PS_SLEEP) ##0 unicast_event;
  endsequence

  sequence s_wake_out;
    (wake_up && !power_save) ##1 !wake_up;
  endsequence

  a_filter_ptr_wrap: assert property (
    wr_filter && (filter_wr_ptr == PTR_W'(FILTER_WORDS - 1)) |=> (filter_wr_ptr == '0)
  ) else $error("filter write pointer did not wrap");

  a_filter_write_slot: assert property (
    wr_filter |=> (wake_filter_contents[$past(filter_wr_ptr)*DATA_W +: DATA_W]
                   == $past(reg_wdata))
  ) else $error("filter word not stored at write pointer");

  a_filter_read_seq: assert property (
    rd_filter |=> (reg_rdata == $past(filter_word))
                  && (filter_rd_ptr == 3'($past(filter_rd_ptr) + 3'h1))
  ) else $error("filter read did not return word and advance");

  a_reset_ptrs: assert property (disable iff (1'b0)
    !rstn |=> (filter_wr_ptr == 3'h0) && (filter_rd_ptr == 3'h0)
  ) else $error("filter pointers not at entry zero after reset");

  a_magic_flag_set: assert property (
    magic_frame_match && magic_wake_enable |=> magic_frame_seen
  ) else $error("magic seen flag not set by magic frame");

  a_magic_disabled: assert property (
    !magic_frame_seen && !magic_wake_enable |=> !magic_frame_seen
  ) else $error("magic seen flag set while magic wake disabled");

  a_frame_flag_clear: assert property (
    wr_wake && reg_wdata[BIT_FRAME_SEEN] && !frame_event |=> !wake_frame_seen
  ) else $error("wake frame flag not cleared by write of one");

  a_frame_flag_set: assert property (
    frame_event |=> wake_frame_seen
  ) else $error("wake frame flag lost its event");

  a_unicast_wake: assert property (
    s_sleeping_hit |=> s_wake_out
  ) else $error("unicast frame did not end power saving");

  a_tx_enable_reg: assert property (
    wr_csum |=> (tx_checksum_enable == $past(reg_wdata[BIT_TX_CSUM_EN]))
  ) else $error("transmit checksum enable not taken from write");

  a_rx_start_bytes: assert property (
    !rx_checksum_start_select |-> (rx_checksum_start_bytes == ETH_HDR_BYTES)
  ) else $error("fixed checksum start is not fourteen bytes");

  a_vlan_reset: assert property (disable iff (1'b0)
    !rstn |=> (vlan_tag_ident_one == VLAN_ID_RESET)
  ) else $error("VLAN tag identifier not all ones after reset");

  a_rdata_idle: assert property (
    !reg_read |=> (reg_rdata == '0)
  ) else $error("read data present without a read");

endmodule : wake_csum_regs
`default_nettype wire

// file: dv/tb.sv
// Self-checking testbench for the wake filter and checksum control register bank.
`timescale 1ns/10ps
`default_nettype none
module tb
  import wake_csum_pkg::*;
;
  logic                          clock;
  logic                          rstn;
  logic [ADDR_W-1:0]             reg_addr;
  logic [DATA_W-1:0]             reg_wdata;
  logic                          reg_write;
  logic                          reg_read;
  logic [DATA_W-1:0]             reg_rdata;
  logic [3:0]                    ev;
  logic                          rx_dest_group;
  logic [FILTER_WORDS*DATA_W-1:0] contents;
  logic                          frame_en;
  logic                          magic_en;
  logic                          ucast_en;
  logic                          frame_seen;
  logic                          magic_seen;
  logic                          power_save;
  logic                          wake_up;
  logic                          tx_en;
  logic                          rx_en;
  logic                          rx_sel;
  logic [7:0]                    start_bytes;
  logic [15:0]                   vlan_id;
  int                            miscompares;
  int                            cmp_count;

  wake_csum_regs uut (
    .clock                    (clock),
    .rstn                     (rstn),
    .reg_addr                 (reg_addr),
    .reg_wdata                (reg_wdata),
    .reg_write                (reg_write),
    .reg_read                 (reg_read),
    .reg_rdata                (reg_rdata),
    .wake_frame_match         (ev[0]),
    .magic_frame_match        (ev[1]),
    .rx_frame_done            (ev[2]),
    .rx_dest_group            (rx_dest_group),
    .sleep_request            (ev[3]),
    .wake_filter_contents     (contents),
    .wake_frame_enable        (frame_en),
    .magic_wake_enable        (magic_en),
    .unicast_wake_enable      (ucast_en),
    .wake_frame_seen          (frame_seen),
    .magic_frame_seen         (magic_seen),
    .power_save               (power_save),
    .wake_up                  (wake_up),
    .tx_checksum_enable       (tx_en),
    .rx_checksum_enable       (rx_en),
    .rx_checksum_start_select (rx_sel),
    .rx_checksum_start_bytes  (start_bytes),
    .vlan_tag_ident_one       (vlan_id)
  );

  // ****************************************
  // Clock and shared tasks
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Every access ends one settled step after the edge that took it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk(what, reg_rdata, exp);
  endtask : rd

  task automatic pulse(input logic [3:0] v, input logic grp);
    @(posedge clock);
    ev            <= v;
    rx_dest_group <= grp;
    @(posedge clock);
    ev <= 4'h0;
    #1;
  endtask : pulse

  task automatic do_reset;
    @(posedge clock);
    rstn <= 1'b0;
    @(posedge clock);
    rstn <= 1'b1;
    #1;
  endtask : do_reset

  function automatic logic [31:0] fv(input int i);
    return 32'h1111_1111 * (i + 1);
  endfunction : fv

  initial begin
    #800000;
    miscompares++;
    conclude();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    miscompares = 0;
    cmp_count   = 0;
    rstn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    ev = 4'h0;
    rx_dest_group = 1'b0;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    #1;
    chk("vlan_reset", {16'h0000, vlan_id}, 32'h0000_FFFF);
    chk("start_reset", {24'h0, start_bytes}, 32'h0000_000E);
    chk("outs_reset", 32'({tx_en, rx_en, rx_sel, frame_en, magic_en, ucast_en, power_save}), 32'h0);
    rd(OFS_WAKE, 32'h0000_0000, "wake_reset");
    rd(OFS_CSUM, 32'h0000_0000, "csum_reset");
    rd(OFS_VLAN, 32'h0000_FFFF, "vlan_rd_reset");
    wr(8'hC0, 32'hFFFF_FFFF);
    rd(8'hC0, 32'h0000_0000, "unmapped");
    rd(OFS_CSUM, 32'h0000_0000, "csum_after_unmapped");
    for (int i = 0; i < 8; i++) rd(OFS_FILTER, 32'h0, "filter_reset");
    // Fill all eight entries, then read them back in order.
    // runs of eight
    for (int i = 0; i < 8; i++) begin
      wr(OFS_FILTER, fv(i));
      chk("filter_fill", contents[32*i +: 32], fv(i));
    end
    for (int i = 0; i < 8; i++) rd(OFS_FILTER, fv(i), "filter_read");
    wr(OFS_FILTER, 32'hDEAD_BEEF);
    chk("filter_wrap", contents[31:0], 32'hDEAD_BEEF);
    chk("filter_wrap_keep", contents[63:32], fv(1));
    rd(OFS_FILTER, 32'hDEAD_BEEF, "read_wrap");
    // Both pointers sit at entry one now; reset must bring them home.
    do_reset();
    chk("filter_cleared", contents[31:0], 32'h0);
    chk("filter_cleared_next", contents[63:32], 32'h0);
    wr(OFS_FILTER, 32'h5555_AAAA);
    chk("wr_ptr_home", contents[31:0], 32'h5555_AAAA);
    rd(OFS_FILTER, 32'h5555_AAAA, "rd_ptr_home");
    // ****************************************
    // Wake control and status
    // ****************************************
    wr(OFS_WAKE, 32'hFFFF_FFFF);
    rd(OFS_WAKE, 32'h0000_0206, "wake_ctrl");
    chk("enables", 32'({frame_en, magic_en, ucast_en}), 32'h7);
    pulse(4'b0010, 1'b1);
    chk("magic_seen", 32'(magic_seen), 32'h1);
    pulse(4'b0001, 1'b1);
    chk("frame_seen", 32'(frame_seen), 32'h1);
    rd(OFS_WAKE, 32'h0000_0266, "both_seen");
    wr(OFS_WAKE, 32'h0000_0226);
    rd(OFS_WAKE, 32'h0000_0246, "clear_magic");
    wr(OFS_WAKE, 32'h0000_0246);
    rd(OFS_WAKE, 32'h0000_0206, "clear_frame");
    pulse(4'b1000, 1'b0);
    chk("sleep", 32'(power_save), 32'h1);
    pulse(4'b0100, 1'b1);
    chk("group_frame", 32'({power_save, wake_up}), 32'h2);
    pulse(4'b0100, 1'b0);
    chk("unicast_wake", 32'({power_save, wake_up}), 32'h1);
    @(posedge clock);
    #1;
    chk("wake_pulse_end", 32'(wake_up), 32'h0);
    wr(OFS_WAKE, 32'h0000_0000);
    pulse(4'b0010, 1'b0);
    chk("magic_off", 32'(magic_seen), 32'h0);
    pulse(4'b0001, 1'b0);
    chk("frame_off", 32'(frame_seen), 32'h0);
    pulse(4'b1000, 1'b0);
    pulse(4'b0111, 1'b0);
    chk("no_wake", 32'({power_save, wake_up}), 32'h2);
    wr(OFS_WAKE, 32'h0000_0002);
    pulse(4'b0010, 1'b0);
    chk("magic_wake", 32'({power_save, wake_up, magic_seen}), 32'h3);
    wr(OFS_WAKE, 32'h0000_0024);
    pulse(4'b1000, 1'b0);
    pulse(4'b0001, 1'b0);
    chk("frame_wake", 32'({power_save, wake_up, frame_seen}), 32'h3);
    rd(OFS_WAKE, 32'h0000_0044, "frame_status");
    // A wake frame in the same cycle as its clear keeps the flag set.
    @(posedge clock);
    reg_addr  <= OFS_WAKE;
    reg_wdata <= 32'h0000_0044;
    reg_write <= 1'b1;
    ev        <= 4'b0001;
    @(posedge clock);
    reg_write <= 1'b0;
    ev        <= 4'h0;
    #1;
    chk("set_wins", 32'(frame_seen), 32'h1);
    // ****************************************
    // Checksum offload and VLAN identifier
    // ****************************************
    // Both paths are idle and pad stripping is off, so every change here is legal.
    // transmit path idle
    wr(OFS_CSUM, 32'hFFFF_FFFF);
    chk("csum_on", 32'({tx_en, rx_en, rx_sel, start_bytes}), 32'h0000_0700);
    rd(OFS_CSUM, 32'h0001_0003, "csum_rd");
    wr(OFS_CSUM, 32'h0001_0000);
    chk("csum_tx_only", 32'({tx_en, rx_en, rx_sel, start_bytes}), 32'h0000_040E);
    wr(OFS_CSUM, 32'h0000_0001);
    chk("csum_rx_only", 32'({tx_en, rx_en, rx_sel}), 32'h2);
    wr(OFS_VLAN, 32'h1234_5678);
    chk("vlan_out", {16'h0000, vlan_id}, 32'h0000_5678);
    rd(OFS_VLAN, 32'h0000_5678, "vlan_rd");
    conclude();
  end
endmodule : tb
`default_nettype wire
